// ===== logic/efsp_store.sv
// Owner security fuse store with virtual cache and policy enforcement
// Summary of operation
// RULE_01 - Each fuse kept as four physical copies
// RULE_02 - Blown physical fuses never return unblown
// RULE_03 - Volatile cache mirrors physical plus pending state
// RULE_04 - Host reads return cache, not array
// RULE_05 - Host names target: cache or physical
// RULE_06 - Cache-only values last until power loss
// RULE_07 - Maker hash 384 bits, owner read-only
// RULE_08 - Maker cancel word: one bit per ID
// RULE_09 - Co-sign fuse needs both signatures
// RULE_10 - Owner cancel: 32 IDs, four copies each
// RULE_11 - Owner root hash field 384 bits
// RULE_12 - Key size only 0, 256 or 384
// RULE_13 - JTAG disable refuses commands and configuration
// RULE_14 - Force internal oscillator during configuration
// RULE_15 - Force key update rejects ratio-less bitstreams
// RULE_16 - Virtual disable refuses virtual writes
// RULE_17 - Lock blocks policy, allows cancellation writes
// RULE_18 - Debug disable refuses processor debug access
// RULE_19 - Disable fuse-stored AES key
// RULE_20 - Disable battery-backed RAM AES key
// RULE_21 - Disable unclonable-function wrapped key
// RULE_22 - Unclonable function re-enrollment fails
// RULE_23 - Read 0x0 unprogrammed, 0xF programmed
// RULE_24 - Physical write also updates cache
`timescale 1ns/1ps
`include "efsp_regs.svh"

module efsp_store #(
	parameter logic [383:0] MFR_HASH = 384'h0
) (
	input  wire logic               I_CLK_SYS,
	input  wire logic               I_SYS_RST,
	input  wire logic               I_FAB_CLEAR,
	input  wire logic               I_REQ_VALID,
	input  wire logic               I_REQ_WRITE,
	input  wire logic               I_REQ_PHYS,
	input  wire efsp_pkg::efsp_idx_t  I_REQ_IDX,
	input  wire efsp_pkg::efsp_word_t I_REQ_WDATA,
	output logic                    O_REQ_READY,
	output logic                    O_REQ_DONE,
	output logic                    O_REQ_ERR,
	output efsp_pkg::efsp_word_t      O_RDATA,
	input  wire logic               I_FW_CHECK,
	input  wire logic               I_FW_OWNER_SIG_OK,
	input  wire logic               I_FW_MFR_SIG_OK,
	output logic                    O_FW_ACCEPT,
	input  wire logic               I_BS_CHECK,
	input  wire logic               I_BS_ENCRYPTED,
	input  wire logic               I_BS_HAS_KUPD_RATIO,
	output logic                    O_BS_REJECT,
	input  wire logic               I_ID_OWNER,
	input  wire logic [4:0]         I_ID_NUM,
	output logic                    O_ID_REVOKED,
	input  wire logic               I_UNCL_REENROLL_REQ,
	output logic                    O_UNCL_REENROLL_OK,
	output logic                    O_UNCL_REENROLL_FAIL,
	output logic                    O_JTAG_CMD_EN,
	output logic                    O_JTAG_CFG_EN,
	output logic                    O_USE_INT_OSC,
	output logic                    O_DEBUG_EN,
	output logic                    O_FUSE_KEY_EN,
	output logic                    O_BATTERY_KEY_EN,
	output logic                    O_WRAPPED_KEY_EN,
	output logic [1:0]              O_KEY_SIZE
);
	import efsp_pkg::*;

	efsp_state_t state;
	efsp_state_t next_state;
	efsp_idx_t   load_idx;
	efsp_idx_t   req_idx;
	efsp_word_t  req_data;
	logic        req_err;
	logic        req_write;
	logic [7:0]  burn_cnt;

	efsp_idx_t   bank_ridx;
	efsp_word_t  bank_rdata;
	logic        bank_wr;

	efsp_idx_t   cache_ridx;
	efsp_word_t  cache_rdata;
	efsp_word_t  policy;
	logic        cache_wr;
	efsp_idx_t   cache_widx;
	efsp_word_t  cache_wdata;

	logic        jtag_dis;
	logic        reject;
	logic        take;
	logic [1:0]  ksz_new;

	assign jtag_dis = policy[`EFSP_B_JTAG_DIS];

	// Policy checks on an incoming request; every refusal leaves fuses alone
	function automatic logic is_policy(input efsp_idx_t idx);
		return (idx == `EFSP_W_POLICY);
	endfunction : is_policy

	assign ksz_new = cache_rdata[`EFSP_B_KSZ_HI:`EFSP_B_KSZ_LO]
		| I_REQ_WDATA[`EFSP_B_KSZ_HI:`EFSP_B_KSZ_LO];

	always_comb begin
		reject = 1'b0;
		if (jtag_dis) begin
			reject = 1'b1; // RULE_13
		end else if (I_REQ_WRITE) begin
			if (I_REQ_IDX >= 5'(`EFSP_NWORDS)) begin
				reject = 1'b1;
			end else if (I_REQ_IDX < 5'(`EFSP_HASH_WORDS)) begin
				reject = 1'b1; // RULE_07
			end else if (!I_REQ_PHYS
				&& policy[`EFSP_B_DIS_VFUSE]) begin
				reject = 1'b1; // RULE_16
			end else if (is_policy(I_REQ_IDX)
				&& policy[`EFSP_B_LOCK]) begin
				reject = 1'b1; // RULE_17
			end else if (is_policy(I_REQ_IDX)
				&& ksz_new == `EFSP_KSZ_BAD) begin
				reject = 1'b1; // RULE_12
			end
		end else if (I_REQ_IDX >= 5'(`EFSP_NWORDS)) begin
			reject = 1'b1;
		end
	end

	assign O_REQ_READY = (state == ST_IDLE);
	assign take        = O_REQ_READY && I_REQ_VALID;

	// Bank lookups follow the load sweep, then the request index; cache lookups use the live index while idle
	assign bank_ridx  = (state == ST_LOAD) ? load_idx : req_idx;
	assign cache_ridx = (state == ST_IDLE) ? I_REQ_IDX : req_idx;

	efsp_fuse_bank #(
		.MFR_HASH (MFR_HASH)
	) u_bank (
		.i_clk       (I_CLK_SYS),
		.i_fab_clear (I_FAB_CLEAR),
		.i_wr        (bank_wr),
		.i_widx      (req_idx),
		.i_wdata     (req_data),
		.i_ridx      (bank_ridx),
		.o_rdata     (bank_rdata)
	);

	efsp_cache u_cache (
		.i_clk    (I_CLK_SYS),
		.i_rst    (I_SYS_RST),
		.i_wr     (cache_wr),
		.i_widx   (cache_widx),
		.i_wdata  (cache_wdata),
		.i_ridx   (cache_ridx),
		.o_rdata  (cache_rdata),
		.o_policy (policy)
	);

	assign bank_wr = (state == ST_BURN) && (burn_cnt == 8'h00);

	// Virtual writes merge in one-way like real fuses do
	always_comb begin
		cache_wr    = 1'b0;
		cache_widx  = req_idx;
		cache_wdata = cache_rdata;
		if (state == ST_LOAD) begin
			cache_wr    = 1'b1; // RULE_03
			cache_widx  = load_idx;
			cache_wdata = bank_rdata;
		end else if (take && I_REQ_WRITE && !reject
			&& !I_REQ_PHYS) begin
			cache_wr    = 1'b1; // RULE_05
			cache_widx  = I_REQ_IDX;
			cache_wdata = cache_rdata | I_REQ_WDATA; // RULE_11
		end else if (bank_wr) begin
			cache_wr    = 1'b1; // RULE_24
			cache_wdata = cache_rdata | req_data;
		end
	end

	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOAD: begin
				if (load_idx == 5'(`EFSP_NWORDS - 1))
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (take) begin
					if (I_REQ_WRITE && I_REQ_PHYS && !reject)
						next_state = ST_BURN;
					else
						next_state = ST_DONE;
				end
			end
			ST_BURN: begin
				if (burn_cnt == 8'h00)
					next_state = ST_DONE;
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST)
			state <= ST_LOAD;
		else
			state <= next_state;
	end

	// Reload sweep runs after every reset, so a power cycle drops virtual values
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST)
			load_idx <= 5'h00;
		else if (state == ST_LOAD)
			load_idx <= load_idx + 5'h01;
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			req_idx   <= 5'h00;
			req_data  <= `EFSP_RST_WORD;
			req_err   <= 1'b0;
			req_write <= 1'b0;
		end else if (take) begin
			req_idx   <= I_REQ_IDX;
			req_data  <= I_REQ_WDATA;
			req_err   <= reject;
			req_write <= I_REQ_WRITE;
		end
	end

	// Burning is slow; the counter stands in for the programming pulse
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST)
			burn_cnt <= 8'h00;
		else if (take)
			burn_cnt <= `EFSP_BURN_CYC - 8'h01;
		else if (state == ST_BURN && burn_cnt != 8'h00)
			burn_cnt <= burn_cnt - 8'h01;
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_REQ_DONE <= 1'b0;
			O_REQ_ERR  <= 1'b0;
			O_RDATA    <= `EFSP_RST_WORD;
		end else begin
			O_REQ_DONE <= (next_state == ST_DONE);
			O_REQ_ERR  <= (next_state == ST_DONE)
				&& (take ? reject : req_err);
			if (take && !I_REQ_WRITE && !reject)
				O_RDATA <= cache_rdata; // RULE_04
		end
	end

	// Policy enables, held at the safe value while the cache reloads
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || state == ST_LOAD) begin
			O_JTAG_CMD_EN    <= 1'b0;
			O_JTAG_CFG_EN    <= 1'b0;
			O_USE_INT_OSC    <= 1'b1;
			O_DEBUG_EN       <= 1'b0;
			O_FUSE_KEY_EN    <= 1'b0;
			O_BATTERY_KEY_EN <= 1'b0;
			O_WRAPPED_KEY_EN <= 1'b0;
			O_KEY_SIZE       <= `EFSP_KSZ_0;
		end else begin
			O_JTAG_CMD_EN    <= !jtag_dis; // RULE_13
			O_JTAG_CFG_EN    <= !jtag_dis; // RULE_13
			O_USE_INT_OSC    <= policy[`EFSP_B_INT_OSC]; // RULE_14
			O_DEBUG_EN       <= !policy[`EFSP_B_DIS_DEBUG]; // RULE_18
			O_FUSE_KEY_EN    <= !policy[`EFSP_B_DIS_FKEY]; // RULE_19
			O_BATTERY_KEY_EN <= !policy[`EFSP_B_DIS_BATTERY_BACKED_KEY_RAM]; // RULE_20
			O_WRAPPED_KEY_EN <= !policy[`EFSP_B_DIS_WRAP]; // RULE_21
			O_KEY_SIZE       <=
				policy[`EFSP_B_KSZ_HI:`EFSP_B_KSZ_LO]; // RULE_12
		end
	end

	efsp_word_t mfr_cancel;
	efsp_word_t own_cancel;
	efsp_idx_t  chk_idx;

	// Cancellation words are shadowed in registers from the cache write port
	assign chk_idx = I_ID_OWNER ? `EFSP_W_OWN_CANCEL : `EFSP_W_MFR_CANCEL;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			mfr_cancel <= `EFSP_RST_WORD;
			own_cancel <= `EFSP_RST_WORD;
		end else if (cache_wr && cache_widx == `EFSP_W_MFR_CANCEL) begin
			mfr_cancel <= cache_wdata; // RULE_08
		end else if (cache_wr && cache_widx == `EFSP_W_OWN_CANCEL) begin
			own_cancel <= cache_wdata; // RULE_10
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_ID_REVOKED <= 1'b0;
		end else begin
			O_ID_REVOKED <= (chk_idx == `EFSP_W_OWN_CANCEL)
				? own_cancel[I_ID_NUM] : mfr_cancel[I_ID_NUM];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || state == ST_LOAD) begin
			O_FW_ACCEPT <= 1'b0;
			O_BS_REJECT <= 1'b0;
		end else begin
			O_FW_ACCEPT <= I_FW_CHECK && I_FW_OWNER_SIG_OK
				&& (I_FW_MFR_SIG_OK
				|| !policy[`EFSP_B_COSIGN]); // RULE_09
			O_BS_REJECT <= I_BS_CHECK && I_BS_ENCRYPTED
				&& !I_BS_HAS_KUPD_RATIO
				&& policy[`EFSP_B_FORCE_KUPD]; // RULE_15
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_UNCL_REENROLL_OK   <= 1'b0;
			O_UNCL_REENROLL_FAIL <= 1'b0;
		end else begin
			O_UNCL_REENROLL_OK   <= I_UNCL_REENROLL_REQ
				&& state != ST_LOAD
				&& !policy[`EFSP_B_DIS_UNCL];
			O_UNCL_REENROLL_FAIL <= I_UNCL_REENROLL_REQ
				&& (state == ST_LOAD
				|| policy[`EFSP_B_DIS_UNCL]); // RULE_22
		end
	end

endmodule : efsp_store

// ===== logic/efsp_regs.svh
// Fuse map, policy bit positions and timing counts of the fuse store
`ifndef EFSP_REGS_SVH
`define EFSP_REGS_SVH

`define EFSP_NWORDS       27
`define EFSP_COPIES       4
`define EFSP_HASH_WORDS   12
`define EFSP_W_MFR_HASH   5'h00
`define EFSP_W_MFR_CANCEL 5'h0C
`define EFSP_W_OWN_CANCEL 5'h0D
`define EFSP_W_OWN_HASH   5'h0E
`define EFSP_W_POLICY     5'h1A

`define EFSP_B_COSIGN     0
`define EFSP_B_NOT_SECURE 1
`define EFSP_B_ENC_DONE   2
`define EFSP_B_ENC_START  3
`define EFSP_B_KSZ_LO     4
`define EFSP_B_KSZ_HI     5
`define EFSP_B_JTAG_DIS   6
`define EFSP_B_INT_OSC    7
`define EFSP_B_FORCE_KUPD 8
`define EFSP_B_DIS_VFUSE  9
`define EFSP_B_LOCK       10
`define EFSP_B_DIS_DEBUG  11
`define EFSP_B_DIS_FKEY   12
`define EFSP_B_DIS_BATTERY_BACKED_KEY_RAM  13
`define EFSP_B_DIS_WRAP   14
`define EFSP_B_DIS_UNCL   15

`define EFSP_KSZ_0        2'b00
`define EFSP_KSZ_256      2'b01
`define EFSP_KSZ_384      2'b10
`define EFSP_KSZ_BAD      2'b11

`define EFSP_RST_WORD     32'h0000_0000
`define EFSP_BURN_CYC     8'h10

`endif

// ===== logic/efsp_pkg.sv
// Types shared by the fuse store modules
package efsp_pkg;

	typedef logic [31:0] efsp_word_t;
	typedef logic [4:0]  efsp_idx_t;

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_BURN = 2'b10,
		ST_DONE = 2'b11
	} efsp_state_t;

	// Two or more blown copies read as programmed
	function automatic logic efsp_fuse_bit(input logic [3:0] copies);
		logic [2:0] cnt;
		cnt = 3'h0;
		for (int c = 0; c < 4; c++) begin
			cnt = cnt + {2'b00, copies[c]};
		end
		return (cnt >= 3'h2);
	endfunction : efsp_fuse_bit

endpackage : efsp_pkg

// ===== logic/efsp_fuse_bank.sv
// Physical quadruple-redundant one-way fuse array
`timescale 1ns/1ps
`include "efsp_regs.svh"

module efsp_fuse_bank #(
	parameter logic [383:0] MFR_HASH = 384'h0
) (
	input  wire logic               i_clk,
	input  wire logic               i_fab_clear,
	input  wire logic               i_wr,
	input  wire efsp_pkg::efsp_idx_t  i_widx,
	input  wire efsp_pkg::efsp_word_t i_wdata,
	input  wire efsp_pkg::efsp_idx_t  i_ridx,
	output efsp_pkg::efsp_word_t      o_rdata
);
	import efsp_pkg::*;

	efsp_word_t fuse [`EFSP_COPIES][`EFSP_NWORDS];

	// Blank state exists only before the part leaves the factory
	always_ff @(posedge i_clk) begin
		if (i_fab_clear) begin
			for (int w = 0; w < `EFSP_NWORDS; w++) begin
				for (int c = 0; c < `EFSP_COPIES; c++) begin
					if (w < `EFSP_HASH_WORDS)
						fuse[c][w] <=
							MFR_HASH[(w % `EFSP_HASH_WORDS)*32 +: 32];
					else
						fuse[c][w] <= `EFSP_RST_WORD;
				end
			end
		end else if (i_wr) begin
			for (int c = 0; c < `EFSP_COPIES; c++) begin
				fuse[c][i_widx] <= fuse[c][i_widx] | i_wdata; // RULE_01 RULE_02
			end
		end
	end

	always_comb begin
		for (int b = 0; b < 32; b++) begin
			o_rdata[b] = efsp_fuse_bit({fuse[3][i_ridx][b],
				fuse[2][i_ridx][b], fuse[1][i_ridx][b],
				fuse[0][i_ridx][b]}); // RULE_23
		end
	end

endmodule : efsp_fuse_bank

// ===== logic/efsp_cache.sv
// Volatile virtual-fuse cache, cleared when power goes away
`timescale 1ns/1ps
`include "efsp_regs.svh"

module efsp_cache (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_wr,
	input  wire efsp_pkg::efsp_idx_t  i_widx,
	input  wire efsp_pkg::efsp_word_t i_wdata,
	input  wire efsp_pkg::efsp_idx_t  i_ridx,
	output efsp_pkg::efsp_word_t      o_rdata,
	output efsp_pkg::efsp_word_t      o_policy
);
	import efsp_pkg::*;

	efsp_word_t mem [`EFSP_NWORDS];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int w = 0; w < `EFSP_NWORDS; w++) begin
				mem[w] <= `EFSP_RST_WORD; // RULE_06
			end
		end else if (i_wr) begin
			mem[i_widx] <= i_wdata;
		end
	end

	assign o_rdata  = mem[i_ridx];
	assign o_policy = mem[`EFSP_W_POLICY];

endmodule : efsp_cache

// ===== bench/efsp_store_assertions.sv
// Port-level checks on the fuse store request and policy outputs
`timescale 1ns/1ps
module efsp_store_checker (
	input wire logic                 I_CLK_SYS,
	input wire logic                 I_SYS_RST,
	input wire logic                 I_REQ_VALID,
	input wire logic                 I_REQ_WRITE,
	input wire logic                 O_REQ_READY,
	input wire logic                 O_REQ_DONE,
	input wire logic                 O_REQ_ERR,
	input wire efsp_pkg::efsp_word_t O_RDATA,
	input wire logic                 I_UNCL_REENROLL_REQ,
	input wire logic                 O_UNCL_REENROLL_OK,
	input wire logic                 O_UNCL_REENROLL_FAIL,
	input wire logic                 O_JTAG_CMD_EN,
	input wire logic                 O_JTAG_CFG_EN,
	input wire logic [1:0]           O_KEY_SIZE
);
	import efsp_pkg::*;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SYS_RST);
	wire take = I_REQ_VALID && O_REQ_READY;

	a_done_one_shot: assert property (O_REQ_DONE |=> !O_REQ_DONE)
		else $error("done longer than one cycle");
	a_err_with_done: assert property (O_REQ_ERR |-> O_REQ_DONE)
		else $error("error without done");
	a_ready_drops: assert property (take |=> !O_REQ_READY)
		else $error("ready stayed high after accept");
	a_done_bound: assert property (take |-> ##[1:17] O_REQ_DONE)
		else $error("no done within burn time");
	a_read_prompt: assert property (take && !I_REQ_WRITE |=> O_REQ_DONE)
		else $error("read not answered next cycle");
	a_rdata_hold: assert property ($changed(O_RDATA) |->
		O_REQ_DONE || $past(I_SYS_RST))
		else $error("read data moved without a read");
	a_jtag_refuse: assert property (O_REQ_DONE && !O_JTAG_CMD_EN |-> O_REQ_ERR)
		else $error("request served while jtag disabled");
	a_jtag_pair: assert property (O_JTAG_CMD_EN == O_JTAG_CFG_EN)
		else $error("jtag enables disagree");
	a_key_legal: assert property (O_KEY_SIZE != 2'b11)
		else $error("illegal key size");
	a_reenroll_one: assert property (I_UNCL_REENROLL_REQ && !I_SYS_RST |=>
		O_UNCL_REENROLL_OK != O_UNCL_REENROLL_FAIL)
		else $error("reenroll answer missing or double");

	c_phys_ok: cover property (take && I_REQ_WRITE ##17 O_REQ_DONE);
	c_refused: cover property (O_REQ_DONE && O_REQ_ERR);
	c_uncl_fail: cover property (O_UNCL_REENROLL_FAIL);
endmodule : efsp_store_checker

bind efsp_store efsp_store_checker u_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
	.I_REQ_VALID(I_REQ_VALID), .I_REQ_WRITE(I_REQ_WRITE),
	.O_REQ_READY(O_REQ_READY), .O_REQ_DONE(O_REQ_DONE),
	.O_REQ_ERR(O_REQ_ERR), .O_RDATA(O_RDATA),
	.I_UNCL_REENROLL_REQ(I_UNCL_REENROLL_REQ),
	.O_UNCL_REENROLL_OK(O_UNCL_REENROLL_OK),
	.O_UNCL_REENROLL_FAIL(O_UNCL_REENROLL_FAIL),
	.O_JTAG_CMD_EN(O_JTAG_CMD_EN), .O_JTAG_CFG_EN(O_JTAG_CFG_EN),
	.O_KEY_SIZE(O_KEY_SIZE)
);

// ===== bench/efsp_host_model.sv
// Programming host model: one fuse request at a time
`timescale 1ns/1ps
module efsp_host_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_ready,
	input  wire logic                 i_done,
	input  wire logic                 i_err,
	input  wire efsp_pkg::efsp_word_t i_rdata,
	output logic                      o_valid = 1'b0,
	output logic                      o_write = 1'b0,
	output logic                      o_phys = 1'b0,
	output efsp_pkg::efsp_idx_t       o_idx = 5'h00,
	output efsp_pkg::efsp_word_t      o_wdata = 32'h0000_0000
);
	import efsp_pkg::*;
	task automatic xfer(input logic wr, input logic ph, input efsp_idx_t ix,
		input efsp_word_t wd, output logic er, output efsp_word_t rd,
		output logic to);
		int n;
		to = 1'b1;
		er = 1'b0;
		rd = 32'h0000_0000;
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_write <= wr;
		o_phys <= ph;
		o_idx <= ix;
		o_wdata <= wd;
		for (n = 0; n < 40 && i_ready !== 1'b1; n++) @(negedge i_clk);
		@(posedge i_clk);
		o_valid <= 1'b0;
		// Released lines carry junk so stale values cannot be relied on
		o_idx <= ~ix;
		o_wdata <= ~wd;
		for (n = 0; n < 40 && to; n++) begin
			@(negedge i_clk);
			if (i_done === 1'b1) begin
				to = 1'b0;
				er = i_err;
				rd = i_rdata;
			end
		end
	endtask : xfer
endmodule : efsp_host_model

// ===== bench/tb.sv
// Self-checking bench for the fuse store
`timescale 1ns/1ps
`include "efsp_regs.svh"
module tb;
	import efsp_pkg::*;
	localparam logic [383:0] HASH = {12{32'h5A3C_0F96}};
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       fab = 1'b1;
	logic       fc = 1'b0, fo = 1'b0, fm = 1'b0, bc = 1'b0;
	logic       enc = 1'b0, rat = 1'b0, rq = 1'b0, own = 1'b0;
	logic [4:0] num = 5'h00;
	logic       rdy, done, err, val, wr, ph;
	logic [4:0] res;
	logic [8:0] pout;
	efsp_idx_t  idx;
	efsp_word_t rdata, wd, pol, oc, mc, d, p;
	int         error_cnt = 0;
	int         checked = 0;
	int         bits[8] = '{0, 7, 8, 11, 12, 13, 14, 15};

	always #5 clk = ~clk;

	efsp_host_model host (.i_clk(clk), .i_ready(rdy), .i_done(done),
		.i_err(err), .i_rdata(rdata), .o_valid(val), .o_write(wr),
		.o_phys(ph), .o_idx(idx), .o_wdata(wd));

	efsp_store #(.MFR_HASH(HASH)) DUT (.I_CLK_SYS(clk), .I_SYS_RST(rst),
		.I_FAB_CLEAR(fab), .I_REQ_VALID(val), .I_REQ_WRITE(wr),
		.I_REQ_PHYS(ph), .I_REQ_IDX(idx), .I_REQ_WDATA(wd),
		.O_REQ_READY(rdy), .O_REQ_DONE(done), .O_REQ_ERR(err),
		.O_RDATA(rdata), .I_FW_CHECK(fc), .I_FW_OWNER_SIG_OK(fo),
		.I_FW_MFR_SIG_OK(fm), .O_FW_ACCEPT(res[4]), .I_BS_CHECK(bc),
		.I_BS_ENCRYPTED(enc), .I_BS_HAS_KUPD_RATIO(rat),
		.O_BS_REJECT(res[3]), .I_ID_OWNER(own), .I_ID_NUM(num),
		.O_ID_REVOKED(res[2]), .I_UNCL_REENROLL_REQ(rq),
		.O_UNCL_REENROLL_OK(res[1]), .O_UNCL_REENROLL_FAIL(res[0]),
		.O_JTAG_CMD_EN(pout[8]), .O_JTAG_CFG_EN(pout[7]),
		.O_USE_INT_OSC(pout[6]), .O_DEBUG_EN(pout[5]),
		.O_FUSE_KEY_EN(pout[4]), .O_BATTERY_KEY_EN(pout[3]),
		.O_WRAPPED_KEY_EN(pout[2]), .O_KEY_SIZE(pout[1:0]));

	function automatic logic [8:0] exp_pol(input efsp_word_t q);
		return {~q[`EFSP_B_JTAG_DIS], ~q[`EFSP_B_JTAG_DIS],
			q[`EFSP_B_INT_OSC], ~q[`EFSP_B_DIS_DEBUG], ~q[`EFSP_B_DIS_FKEY],
			~q[`EFSP_B_DIS_BATTERY_BACKED_KEY_RAM], ~q[`EFSP_B_DIS_WRAP], q[5:4]};
	endfunction : exp_pol

	task automatic close_out();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic req(input logic w_, input logic ph_, input efsp_idx_t ix,
		input efsp_word_t dat, output logic er, output efsp_word_t rd);
		logic to;
		host.xfer(w_, ph_, ix, dat, er, rd, to);
		chk("done", 0, 32'(to));
		if (to)
			close_out();
		@(negedge clk);
	endtask : req

	task automatic w(input logic ph_, input efsp_idx_t ix,
		input efsp_word_t dat, input logic ee);
		logic e;
		efsp_word_t rd;
		req(1'b1, ph_, ix, dat, e, rd);
		chk("write err", 32'(ee), 32'(e));
		chk("policy", 32'(exp_pol(pol)), 32'(pout));
	endtask : w

	task automatic r(input efsp_idx_t ix, input efsp_word_t ex,
		input logic ee);
		logic e;
		efsp_word_t rd;
		req(1'b0, 1'b0, ix, 32'h0000_0000, e, rd);
		chk("read err", 32'(ee), 32'(e));
		if (!ee)
			chk("rdata", ex, rd);
	endtask : r

	// Drives every check input at random and predicts all five answers
	task automatic look();
		logic [7:0] v;
		logic [4:0] ex;
		v = 8'($urandom);
		@(posedge clk);
		{fc, fo, fm, bc, enc, rat, rq, own} <= v;
		num <= 5'($urandom);
		@(posedge clk);
		@(negedge clk);
		ex = {fc & fo & (fm | ~pol[0]), bc & enc & ~rat & pol[8],
			own ? oc[num] : mc[num], rq & ~pol[15], rq & pol[15]};
		chk("checks", 32'(ex), 32'(res));
	endtask : look

	task automatic reboot(input logic clr);
		int n;
		@(posedge clk);
		rst <= 1'b1;
		fab <= clr;
		@(posedge clk);
		fab <= 1'b0;
		rst <= 1'b0;
		// Ready still shows the old state until the reset edge settles
		@(negedge clk);
		for (n = 0; n < 40 && rdy !== 1'b1; n++) @(negedge clk);
		chk("load", 27, 32'(n));
		if (n >= 40)
			close_out();
		@(negedge clk);
		chk("policy", 32'(exp_pol(pol)), 32'(pout));
	endtask : reboot

	initial begin
		void'($urandom(32'h978c));
		{pol, oc, mc} = '0;
		reboot(1'b1);
		r(0, HASH[31:0], 0);
		w(0, 0, 32'hFFFF_FFFF, 1);
		w(1, 11, 32'h0000_0001, 1);
		r(11, HASH[383:352], 0);
		r(27, 0, 1);
		d = $urandom;
		w(0, 14, d, 0);
		r(14, d, 0);
		p = $urandom;
		w(1, 25, p, 0);
		r(25, p, 0);
		mc = $urandom;
		w(0, 12, mc, 0);
		oc = $urandom;
		w(1, 13, oc, 0);
		repeat (40) look();
		w(0, 26, 32'h0000_0030, 1);
		pol = 32'h0000_0020;
		w(0, 26, pol, 0);
		foreach (bits[i]) begin
			pol[bits[i]] = 1'b1;
			w(0, 26, pol, 0);
			repeat (4) look();
		end
		{pol, mc} = '0;
		reboot(1'b0);
		r(14, 0, 0);
		r(25, p, 0);
		repeat (8) look();
		pol = 32'h0000_0200;
		w(1, 26, pol, 0);
		w(0, 14, 32'h0000_0001, 1);
		w(1, 14, d, 0);
		pol[10] = 1'b1;
		w(1, 26, pol, 0);
		w(1, 26, 32'h0000_8000, 1);
		oc = oc | $urandom;
		w(1, 13, oc, 0);
		repeat (8) look();
		{pol, oc} = '0;
		reboot(1'b1);
		pol = 32'h0000_0040;
		w(1, 26, pol, 0);
		r(26, 0, 1);
		w(1, 14, 32'h0000_0001, 1);
		close_out();
	end
endmodule : tb
